/* File: core/bcs_cycle_table.sv */
// Per-class, per-cycle bus role lookup
`timescale 1ns/10ps
module bcs_cycle_table
  import bcs_pkg::*;
(
  // Lookup
  bcs_step_if.table_side st
);

  logic [2:0] total;

  always_comb begin
    st.src  = BCS_A_DUMMY;
    st.wr   = 1'b0;
    st.dsel = BCS_D_NONE;
    total   = BCS_CYC_INH2;
    // First two cycles are common to every class here
    if (st.cyc == 3'h1) begin
      st.src = BCS_A_OPC;
    end else if (st.cyc == 3'h2) begin
      st.src = BCS_A_OPC1;
    end
    case (st.cls)
      BCS_JUMP_INDEXED: begin
        total = BCS_CYC_JUMP;
      end
      BCS_ACC_READ, BCS_ACC_STORE: begin
        total = BCS_CYC_ACC;
        if (st.cyc == 3'h4) begin
          st.src = BCS_A_EA;
          st.wr  = (st.cls == BCS_ACC_STORE);
          if (st.cls == BCS_ACC_STORE) begin
            st.dsel = BCS_D_LO;
          end
        end
      end
      BCS_LOAD_WIDE, BCS_STORE_WIDE: begin
        total = BCS_CYC_WIDE;
        if (st.cyc == 3'h4) begin
          st.src = BCS_A_EA;
        end else if (st.cyc == 3'h5) begin
          st.src = BCS_A_EA1;
        end
        if (st.cls == BCS_STORE_WIDE && st.cyc >= 3'h4) begin
          st.wr   = 1'b1;
          st.dsel = (st.cyc == 3'h4) ? BCS_D_HI : BCS_D_LO;
        end
      end
      BCS_RMW, BCS_RMW_TEST: begin
        total = BCS_CYC_LONG;
        if (st.cyc == 3'h4) begin
          st.src = BCS_A_EA;
        end else if (st.cyc == 3'h6 && st.cls == BCS_RMW) begin
          st.src  = BCS_A_EA;
          st.wr   = 1'b1;
          st.dsel = BCS_D_RES;
        end
      end
      BCS_DOUBLE_ARITH: begin
        total = BCS_CYC_LONG;
        if (st.cyc == 3'h4) begin
          st.src = BCS_A_EA;
        end else if (st.cyc == 3'h5) begin
          st.src = BCS_A_EA1;
        end
      end
      BCS_CALL_SUBROUTINE: begin
        total = BCS_CYC_LONG;
        if (st.cyc == 3'h4) begin
          st.src = BCS_A_EA;
        end else if (st.cyc == 3'h5) begin
          st.src  = BCS_A_SP;
          st.wr   = 1'b1;
          st.dsel = BCS_D_RETLO;
        end else if (st.cyc == 3'h6) begin
          st.src  = BCS_A_SPM1;
          st.wr   = 1'b1;
          st.dsel = BCS_D_RETHI;
        end
      end
      BCS_INH_REG: begin
        total = BCS_CYC_INH2;
      end
      BCS_INH_DUMMY: begin
        total = BCS_CYC_INH3;
      end
      BCS_INH_STACK: begin
        total = BCS_CYC_INH3;
        if (st.cyc == 3'h3) begin
          st.src = BCS_A_SP;
        end
      end
      default: begin
        total = BCS_CYC_INH2;
      end
    endcase
    st.last = (st.cyc == total);
  end

endmodule

/* File: core/bcs_pkg.sv */
// Constants and types for the indexed/inherent bus-cycle sequencer
package bcs_pkg;

  localparam logic [15:0] BCS_DUMMY_ADDR = 16'hFFFF;
  localparam logic [15:0] BCS_RESET_ADDR = 16'hFFFF;
  localparam logic [7:0]  BCS_RESET_BYTE = 8'h00;
  localparam logic [15:0] BCS_RET_STEP   = 16'h0002;

  // Cycles per instruction class
  localparam logic [2:0] BCS_CYC_JUMP  = 3'h3;
  localparam logic [2:0] BCS_CYC_ACC   = 3'h4;
  localparam logic [2:0] BCS_CYC_WIDE  = 3'h5;
  localparam logic [2:0] BCS_CYC_LONG  = 3'h6;
  localparam logic [2:0] BCS_CYC_INH2  = 3'h2;
  localparam logic [2:0] BCS_CYC_INH3  = 3'h3;

  typedef enum logic [3:0] {
    BCS_JUMP_INDEXED,
    BCS_ACC_READ,
    BCS_ACC_STORE,
    BCS_LOAD_WIDE,
    BCS_STORE_WIDE,
    BCS_RMW,
    BCS_RMW_TEST,
    BCS_DOUBLE_ARITH,
    BCS_CALL_SUBROUTINE,
    BCS_INH_REG,
    BCS_INH_DUMMY,
    BCS_INH_STACK
  } bcs_class_e;

  typedef enum logic [2:0] {
    BCS_A_OPC, BCS_A_OPC1, BCS_A_DUMMY, BCS_A_EA, BCS_A_EA1,
    BCS_A_SP, BCS_A_SPM1
  } bcs_asrc_e;

  typedef enum logic [2:0] {
    BCS_D_NONE, BCS_D_HI, BCS_D_LO, BCS_D_RES, BCS_D_RETLO, BCS_D_RETHI
  } bcs_dsel_e;

endpackage

/* File: core/bcs_sequencer.sv */
// Bus-cycle sequencer for indexed and inherent instructions
`timescale 1ns/10ps
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int AW = 16
)(
  // Clock and reset
  input  wire logic          SYS_CLK,
  input  wire logic          RESET_N,
  // Instruction request
  input  wire logic          START,
  input  wire logic [3:0]    CLASS,
  input  wire logic [AW-1:0] OPCODE_ADDR,
  input  wire logic [AW-1:0] INDEX,
  input  wire logic [AW-1:0] STACK_PTR,
  input  wire logic [15:0]   STORE_DATA,
  input  wire logic [7:0]    RESULT,
  // Processor bus
  output logic [AW-1:0]      ADDR,
  output logic               RW,
  input  wire logic [7:0]    D_IN,
  output logic [7:0]         D_OUT,
  output logic               D_OE,
  // Status
  output logic               BUSY,
  output logic [2:0]         CYCLE,
  output logic               LAST,
  output logic [AW-1:0]      EFF_ADDR,
  output logic [15:0]        READ_DATA
);

  typedef enum logic {BCS_IDLE, BCS_RUN} bcs_state_e;

  bcs_state_e      state_r,  state_nxt;
  bcs_class_e      cls_r,    cls_nxt;
  logic [2:0]      cyc_r,    cyc_nxt;
  bcs_asrc_e       src_r,    src_nxt;
  logic [AW-1:0]   pc_r,     pc_nxt;
  logic [AW-1:0]   x_r,      x_nxt;
  logic [AW-1:0]   sp_r,     sp_nxt;
  logic [15:0]     wd_r,     wd_nxt;
  logic [7:0]      res_r,    res_nxt;
  logic [7:0]      off_r,    off_nxt;
  logic [15:0]     rd_r,     rd_nxt;
  logic [AW-1:0]   addr_r,   addr_nxt;
  logic            rw_r,     rw_nxt;
  logic [7:0]      dout_r,   dout_nxt;
  logic            doe_r,    doe_nxt;
  logic            last_r,   last_nxt;
  logic [AW-1:0]   ea_r,     ea_nxt;

  logic            begin_new;
  logic [AW-1:0]   ea_calc;
  logic [AW-1:0]   ret_addr;

  bcs_step_if st ();

  bcs_cycle_table u_table (
    .st (st)
  );

  // Offset is unsigned: zero-extended before the add
  assign ea_calc  = x_r + AW'(off_r);
  assign ret_addr = pc_r + AW'(BCS_RET_STEP);
  // A new request is taken when idle or in the final cycle
  assign begin_new = START && (state_r == BCS_IDLE || last_r);

  always_comb begin
    state_nxt = state_r;
    cls_nxt   = cls_r;
    cyc_nxt   = cyc_r;
    pc_nxt    = pc_r;
    x_nxt     = x_r;
    sp_nxt    = sp_r;
    wd_nxt    = wd_r;
    res_nxt   = res_r;
    off_nxt   = off_r;
    rd_nxt    = rd_r;
    ea_nxt    = ea_r;

    // Sample the data bus at the end of read cycles at BCS_A_OPC1, BCS_A_EA and BCS_A_EA1
    if (state_r == BCS_RUN && !rw_r) begin
      ea_nxt = ea_r;
    end
    if (state_r == BCS_RUN && rw_r) begin
      if (src_r == BCS_A_OPC1) begin
        off_nxt = D_IN;
      end else if (src_r == BCS_A_EA) begin
        if (cls_r == BCS_LOAD_WIDE || cls_r == BCS_DOUBLE_ARITH) begin
          rd_nxt[15:8] = D_IN;
        end else begin
          rd_nxt[7:0] = D_IN;
        end
      end else if (src_r == BCS_A_EA1) begin
        rd_nxt[7:0] = D_IN;
      end
    end
    // Effective address follows the offset once fetched
    if (state_r == BCS_RUN && cyc_r == 3'h3) begin
      ea_nxt = ea_calc;
    end

    if (begin_new) begin
      state_nxt = BCS_RUN;
      cls_nxt   = bcs_class_e'(CLASS);
      cyc_nxt   = 3'h1;
      pc_nxt    = OPCODE_ADDR;
      x_nxt     = INDEX;
      sp_nxt    = STACK_PTR;
      wd_nxt    = STORE_DATA;
      res_nxt   = RESULT;
    end else if (state_r == BCS_RUN && last_r) begin
      state_nxt = BCS_IDLE;
      cyc_nxt   = 3'h0;
    end else if (state_r == BCS_RUN) begin
      cyc_nxt   = cyc_r + 3'h1;
    end
    // Late result: the write cycle takes the value presented now
    if (state_r == BCS_RUN && !begin_new) begin
      res_nxt = RESULT;
    end
  end

  // Table looks up the cycle about to start
  assign st.cls = cls_nxt;
  assign st.cyc = cyc_nxt;

  always_comb begin
    addr_nxt = BCS_DUMMY_ADDR;
    rw_nxt   = 1'b1;
    dout_nxt = BCS_RESET_BYTE;
    doe_nxt  = 1'b0;
    last_nxt = 1'b0;
    src_nxt  = BCS_A_DUMMY;
    if (state_nxt == BCS_RUN) begin
      src_nxt  = st.src;
      rw_nxt   = !st.wr;
      doe_nxt  = st.wr;
      last_nxt = st.last;
      case (st.src)
        BCS_A_OPC:   addr_nxt = pc_nxt;
        BCS_A_OPC1:  addr_nxt = pc_nxt + AW'(1);
        BCS_A_EA:    addr_nxt = ea_nxt;
        BCS_A_EA1:   addr_nxt = ea_nxt + AW'(1);
        BCS_A_SP:    addr_nxt = sp_nxt;
        BCS_A_SPM1:  addr_nxt = sp_nxt - AW'(1);
        default:     addr_nxt = BCS_DUMMY_ADDR;
      endcase
      case (st.dsel)
        BCS_D_HI:    dout_nxt = wd_nxt[15:8];
        BCS_D_LO:    dout_nxt = wd_nxt[7:0];
        BCS_D_RES:   dout_nxt = res_nxt;
        BCS_D_RETLO: dout_nxt = ret_addr[7:0];
        BCS_D_RETHI: dout_nxt = ret_addr[15:8];
        default:     dout_nxt = BCS_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= BCS_IDLE;
      cls_r   <= BCS_INH_REG;
      cyc_r   <= 3'h0;
      src_r   <= BCS_A_DUMMY;
      pc_r    <= '0;
      x_r     <= '0;
      sp_r    <= '0;
      wd_r    <= '0;
      res_r   <= BCS_RESET_BYTE;
      off_r   <= BCS_RESET_BYTE;
      rd_r    <= '0;
      addr_r  <= BCS_RESET_ADDR;
      rw_r    <= 1'b1;
      dout_r  <= BCS_RESET_BYTE;
      doe_r   <= 1'b0;
      last_r  <= 1'b0;
      ea_r    <= '0;
    end else begin
      state_r <= state_nxt;
      cls_r   <= cls_nxt;
      cyc_r   <= cyc_nxt;
      src_r   <= src_nxt;
      pc_r    <= pc_nxt;
      x_r     <= x_nxt;
      sp_r    <= sp_nxt;
      wd_r    <= wd_nxt;
      res_r   <= res_nxt;
      off_r   <= off_nxt;
      rd_r    <= rd_nxt;
      addr_r  <= addr_nxt;
      rw_r    <= rw_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      last_r  <= last_nxt;
      ea_r    <= ea_nxt;
    end
  end

  assign ADDR      = addr_r;
  assign RW        = rw_r;
  assign D_OUT     = dout_r;
  assign D_OE      = doe_r;
  assign BUSY      = (state_r == BCS_RUN);
  assign CYCLE     = cyc_r;
  assign LAST      = last_r;
  assign EFF_ADDR  = ea_r;
  assign READ_DATA = rd_r;

endmodule

/* File: core/bcs_step_if.sv */
// Step lookup carrier between the sequencer and its cycle table
`timescale 1ns/10ps
interface bcs_step_if;
  import bcs_pkg::*;
  bcs_class_e cls;
  logic [2:0] cyc;
  bcs_asrc_e  src;
  logic       wr;
  bcs_dsel_e  dsel;
  logic       last;

  modport seq (output cls, output cyc, input src, input wr, input dsel,
               input last);
  modport table_side (input cls, input cyc, output src, output wr,
                      output dsel, output last);
endinterface

/* File: tb/bcs_mem_model.sv */
// Memory stand-in on the processor bus
`timescale 1ns/10ps
module bcs_mem_model (
  // Bus
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic        rw,
  output logic [7:0]       d_in
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge clk) begin
    if (rw) last_r <= addr[7:0] ^ addr[15:8] ^ 8'hC3;
  end
  // Not driving during writes, so show the inverse rather than stale data
  assign d_in = rw ? (addr[7:0] ^ addr[15:8] ^ 8'hC3) : ~last_r;
endmodule

/* File: tb/bcs_seq_monitor.sv */
// Concurrent checks of the sequencer bus cycles
`timescale 1ns/10ps
module bcs_seq_monitor #(
  parameter int AW = 16
)(
  // Clock and reset
  input wire logic          SYS_CLK,
  input wire logic          RESET_N,
  // Request
  input wire logic          START,
  input wire logic [3:0]    CLASS,
  input wire logic [AW-1:0] OPCODE_ADDR,
  input wire logic [AW-1:0] STACK_PTR,
  // Bus and status
  input wire logic [AW-1:0] ADDR,
  input wire logic          RW,
  input wire logic          D_OE,
  input wire logic          BUSY,
  input wire logic [2:0]    CYCLE,
  input wire logic          LAST,
  input wire logic [AW-1:0] EFF_ADDR
);
  logic [3:0]    cls_r;
  logic [AW-1:0] opc_r;
  logic [AW-1:0] sp_r;
  // Latched at the taking edge, since the request inputs may move on
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cls_r <= 4'h0;
      opc_r <= '0;
      sp_r  <= '0;
    end else if (START && (!BUSY || LAST)) begin
      cls_r <= CLASS;
      opc_r <= OPCODE_ADDR;
      sp_r  <= STACK_PTR;
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  a_first_fetch: assert property (
    START && (!BUSY || LAST) |=> CYCLE == 3'h1 && ADDR == opc_r && RW)
    else $error("opcode fetch missing after start");
  a_next_fetch: assert property (
    CYCLE == 3'h1 |=> ADDR == opc_r + 16'h1 && RW && CYCLE == 3'h2)
    else $error("second cycle not at opcode address plus one");
  a_jump_end: assert property (
    CYCLE == 3'h1 && cls_r == 4'h0 |-> ##2 LAST && ADDR == 16'hFFFF && RW)
    else $error("indexed jump not ending with dummy in cycle three");
  a_acc_fourth: assert property (
    CYCLE == 3'h1 && cls_r == 4'h1 |-> ##3 LAST && ADDR == EFF_ADDR && RW)
    else $error("byte read not at effective address in cycle four");
  a_store_write: assert property (
    cls_r == 4'h2 && CYCLE == 3'h4 |-> !RW && D_OE && LAST
    && ADDR == EFF_ADDR)
    else $error("byte store not written in cycle four");
  a_wide_pair: assert property (
    (cls_r == 4'h3 || cls_r == 4'h4) && CYCLE == 3'h4 |-> ADDR == EFF_ADDR
    && RW == (cls_r == 4'h3) ##1 LAST && ADDR == EFF_ADDR + 16'h1
    && RW == (cls_r == 4'h3))
    else $error("wide transfer bytes out of place");
  a_rmw_order: assert property (
    (cls_r == 4'h5 || cls_r == 4'h6) && CYCLE == 3'h3 |-> ADDR == 16'hFFFF
    ##1 ADDR == EFF_ADDR && RW ##1 ADDR == 16'hFFFF && RW
    ##1 LAST && RW == (cls_r == 4'h6)
    && ADDR == (cls_r == 4'h6 ? 16'hFFFF : EFF_ADDR))
    else $error("read-modify-write order broken");
  a_double_tail: assert property (
    cls_r == 4'h7 && CYCLE == 3'h5 |-> ADDR == EFF_ADDR + 16'h1 && RW
    ##1 LAST && ADDR == 16'hFFFF && RW)
    else $error("double arithmetic tail wrong");
  a_call_push: assert property (
    cls_r == 4'h8 && CYCLE == 3'h4 |-> ADDR == EFF_ADDR && RW
    ##1 ADDR == sp_r && !RW ##1 LAST && ADDR == sp_r - 16'h1 && !RW)
    else $error("subroutine call pushes wrong");
  a_inh_short: assert property (
    cls_r == 4'h9 && CYCLE == 3'h1 |=> LAST && CYCLE == 3'h2)
    else $error("register-only instruction not two cycles");
  a_dummy_tail: assert property (
    cls_r == 4'hA && CYCLE == 3'h3 |-> LAST && ADDR == 16'hFFFF && RW)
    else $error("index add or double shift tail wrong");
  a_stack_peek: assert property (
    cls_r == 4'hB && CYCLE == 3'h3 |-> LAST && ADDR == sp_r && RW)
    else $error("stack adjust not reading old stack pointer");
endmodule

bind bcs_sequencer bcs_seq_monitor #(.AW(AW)) u_mon (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .START(START), .CLASS(CLASS),
  .OPCODE_ADDR(OPCODE_ADDR), .STACK_PTR(STACK_PTR), .ADDR(ADDR), .RW(RW),
  .D_OE(D_OE), .BUSY(BUSY), .CYCLE(CYCLE), .LAST(LAST),
  .EFF_ADDR(EFF_ADDR));

/* File: tb/test_indexed_inherent_bus_cycle_sequencer.sv */
// Self-checking bench for the bus-cycle sequencer
`timescale 1ns/10ps
module test_indexed_inherent_bus_cycle_sequencer;
  logic        sys_clk;
  logic        reset_n;
  logic        start;
  logic [3:0]  cls;
  logic [15:0] opc;
  logic [15:0] idx;
  logic [15:0] sp;
  logic [15:0] sdat;
  logic [7:0]  res;
  logic [15:0] addr;
  logic        rw;
  logic [7:0]  d_in;
  logic [7:0]  d_out;
  logic        d_oe;
  logic        busy;
  logic [2:0]  cycle;
  logic        last;
  logic [15:0] eff;
  logic [15:0] rdat;
  int          bad_count;
  int          checks;
  int          ncyc;
  logic [7:0]  wq[$];
  localparam int NC[12] = '{3, 4, 4, 5, 5, 6, 6, 6, 6, 2, 3, 3};

  bcs_sequencer u_dut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .START(start), .CLASS(cls),
    .OPCODE_ADDR(opc), .INDEX(idx), .STACK_PTR(sp), .STORE_DATA(sdat),
    .RESULT(res), .ADDR(addr), .RW(rw), .D_IN(d_in), .D_OUT(d_out),
    .D_OE(d_oe), .BUSY(busy), .CYCLE(cycle), .LAST(last),
    .EFF_ADDR(eff), .READ_DATA(rdat));
  bcs_mem_model u_mem (.clk(sys_clk), .addr(addr), .rw(rw), .d_in(d_in));

  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hC3;
  endfunction

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One instruction with an idle cycle before it; outputs are read at
  // the falling edge, where each bus cycle has settled
  task automatic run(input logic [3:0] c);
    int n;
    wq.delete();
    @(posedge sys_clk);
    cls <= c;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    n = 0;
    ncyc = 0;
    while (ncyc == 0) begin
      @(negedge sys_clk);
      n++;
      if (rw === 1'b0) wq.push_back(d_out);
      if (last === 1'b1) ncyc = n;
      if (n > 9) begin
        bad_count++;
        test_done();
      end
    end
    // Let the closing edge land so captured status has settled
    @(negedge sys_clk);
  endtask

  task automatic t_classes(input logic [15:0] o, input logic [15:0] x);
    logic [15:0] ea;
    logic [15:0] ret;
    logic [7:0]  ew[$];
    @(posedge sys_clk);
    opc <= o;
    idx <= x;
    ea = x + {8'h00, mem(o + 16'h1)};
    ret = o + 16'h2;
    for (int c = 0; c < 12; c++) begin
      run(4'(c));
      chk("cycles", 16'(ncyc), 16'(NC[c]));
      if (c <= 8) chk("eff", eff, ea);
      if (c == 1) chk("rbyte", {8'h00, rdat[7:0]}, {8'h00, mem(ea)});
      if (c == 3 || c == 7) begin
        chk("rdat", rdat, {mem(ea), mem(ea + 16'h1)});
      end
      case (c)
        2: ew = {sdat[7:0]};
        4: ew = {sdat[15:8], sdat[7:0]};
        5: ew = {res};
        8: ew = {ret[7:0], ret[15:8]};
        default: ew = {};
      endcase
      chk("writes", 16'(wq.size()), 16'(ew.size()));
      for (int i = 0; i < ew.size() && i < wq.size(); i++) begin
        chk("wbyte", {8'h00, wq[i]}, {8'h00, ew[i]});
      end
    end
    $display("class sweep done at %h", o);
  endtask

  // Start held high: a request in cycle one is ignored, one in the last
  // cycle starts the next instruction with no gap
  task automatic t_b2b();
    @(posedge sys_clk);
    cls <= 4'h9;
    start <= 1'b1;
    @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      chk("b2b addr", addr, opc + 16'(k % 2));
      chk("b2b cycle", {13'h0, cycle}, 16'(k % 2 + 1));
    end
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (3) @(posedge sys_clk);
    $display("back to back done");
  endtask

  // Reset pulled in the middle of a call: outputs go idle at once, and
  // a spare class code runs as a two-cycle instruction after release
  task automatic t_reset_mid();
    @(posedge sys_clk);
    cls <= 4'h8;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(negedge sys_clk);
    chk("rst addr", addr, 16'hFFFF);
    chk("rst state", {12'h0, busy, cycle}, 16'h0000);
    chk("rst drive", {14'h0, d_oe, last}, 16'h0000);
    chk("rst data", rdat, 16'h0000);
    chk("rst eff", eff, 16'h0000);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    run(4'hC);
    chk("spare code", 16'(ncyc), 16'h0002);
    $display("mid-run reset done");
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    bad_count = 0;
    checks = 0;
    reset_n = 1'b0;
    start = 1'b0;
    cls = 4'h0;
    opc = 16'h0000;
    idx = 16'h0000;
    sp = 16'h2000;
    sdat = 16'hBEEF;
    res = 8'h5A;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    chk("idle addr", addr, 16'hFFFF);
    chk("idle busy", {15'h0, busy}, 16'h0000);
    t_classes(16'h1234, 16'hFF80);
    t_classes(16'h00C2, 16'h1000);
    t_b2b();
    t_reset_mid();
    test_done();
  end
endmodule
